//--- bench/testbench.sv
// testbench: register tests of usbsfc_core over axi4-lite
// assumes usbsfc_sie_model drives the engine side
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_errors++; $display("CHECK FAILED %0t got %0h exp %0h", $time, a, e); end end
module testbench
  import usbsfc_pkg::*;
;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic usb_bus_reset = 1'b0;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'h1;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic sie_setup_ok, sie_in_done, sie_in_token, sie_token_active, sie_nak_sent;
  logic sie_check_fail, sie_fifo0_error, sie_out_data, sie_out_zero, sie_pkt_setup;
  logic sie_pkt_other, sie_iso_in_evt, sie_iso_out_evt, fifo_read_strobe;
  logic [4:0] fifo_ready, fifo_flush, force_underrun;
  logic [2:0] endpoint_select;
  logic fifo_request, fifo_tx_dir, remote_wake_en, data_pid_toggle, usb_irq;
  logic [6:0] active_address;
  logic [4:1] ep_pipe_direction;
  int n_errors = 0;
  int n_checks = 0;
  always #5 clk_sys = ~clk_sys;
  usbsfc_core u_usbsfc_core (.*);
  usbsfc_sie_model u_usbsfc_sie_model (.*);
  // ----------------------------------------
  // bus and event tasks
  // ----------------------------------------
  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rc(input logic [31:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    `CHK(s_axi_rdata, {24'h0, e})
  endtask
  task automatic ev(input int n);
    u_usbsfc_sie_model.fire(n);
  endtask
  task automatic results;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_errors++;
    results();
  end
  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial begin
    repeat (6) @(posedge clk_sys);
    reset <= 1'b0;
    rc(32'h94, 8'h40);
    rc(32'h98, 8'h00);
    rc(32'h9c, 8'h1a);
    rc(32'h8c, 8'h00);
    rc(32'h88, 8'h00);
    wr(32'h9c, 8'hff);
    rc(32'h9c, 8'h1f);
    `CHK({ep_pipe_direction, data_pid_toggle}, 5'h1f)
    wr(32'h9c, 8'h1e);
    `CHK(data_pid_toggle, 1'b0)
    wr(32'h8c, 8'h0b);
    `CHK({active_address, remote_wake_en}, 8'h0b)
    wr(32'h94, 8'h01);
    wr(32'h8c, 8'h14);
    `CHK(active_address, 7'h05)
    ev(1);
    `CHK(active_address, 7'h0a)
    wr(32'h94, 8'h00);
    ev(3);
    ev(4);
    ev(5);
    rc(32'h94, 8'h66);
    `CHK(usb_irq, 1'b1)
    ev(0);
    rc(32'h94, 8'h62);
    wr(32'h94, 8'h00);
    rc(32'h94, 8'h40);
    `CHK(usb_irq, 1'b0)
    u_usbsfc_sie_model.levels(1'b1, 1'b1, 5'h0);
    rc(32'h94, 8'h08);
    wr(32'h94, 8'h80);
    ev(2);
    `CHK(usb_irq, 1'b0)
    wr(32'h94, 8'h00);
    ev(2);
    `CHK(usb_irq, 1'b1)
    rc(32'h100, 8'h01);
    wr(32'h94, 8'h00);
    `CHK(usb_irq, 1'b0)
    wr(32'h88, 8'h02);
    wr(32'h98, 8'h04);
    `CHK(force_underrun, 5'h04)
    ev(1);
    `CHK(force_underrun, 5'h00)
    wr(32'h98, 8'h00);
    u_usbsfc_sie_model.levels(1'b0, 1'b0, 5'h04);
    ev(6);
    ev(7);
    rc(32'h98, 8'he0);
    ev(8);
    rc(32'h98, 8'hc0);
    ev(11);
    rc(32'h98, 8'h40);
    wr(32'h98, 8'h03);
    `CHK({fifo_request, fifo_tx_dir}, 2'b11)
    wr(32'h98, 8'h01);
    `CHK({fifo_request, fifo_tx_dir}, 2'b10)
    wr(32'h98, 8'h08);
    ev(9);
    `CHK(usb_irq, 1'b1)
    rc(32'h100, 8'h02);
    wr(32'h98, 8'h00);
    ev(10);
    `CHK(usb_irq, 1'b0)
    wr(32'h98, 8'h1b);
    usb_bus_reset <= 1'b1;
    @(posedge clk_sys);
    usb_bus_reset <= 1'b0;
    u_usbsfc_sie_model.levels(1'b0, 1'b0, 5'h0);
    rc(32'h98, 8'h00);
    wr(32'h88, 8'h05);
    wr(32'h98, 8'h04);
    `CHK(force_underrun, 5'h00)
    wr(32'h200, 8'hff);
    `CHK(resp, USBSFC_RESP_SLVERR)
    rc(32'h200, 8'h00);
    `CHK(resp, USBSFC_RESP_SLVERR)
    results();
  end
endmodule
`default_nettype wire

//--- bench/usbsfc_core_asserts.sv
// usbsfc_core_asserts: port-level checks of the usb sie status block
// assumes one clk_sys domain; bound into every usbsfc_core instance
`timescale 1ns/1ps
`default_nettype none
module usbsfc_core_asserts (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic usb_bus_reset,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic sie_in_done,
  input wire logic sie_check_fail,
  input wire logic sie_fifo0_error,
  input wire logic sie_pkt_setup,
  input wire logic sie_pkt_other,
  input wire logic sie_out_data,
  input wire logic sie_out_zero,
  input wire logic [2:0] endpoint_select,
  input wire logic fifo_request,
  input wire logic fifo_tx_dir,
  input wire logic [4:0] fifo_flush,
  input wire logic [4:0] force_underrun,
  input wire logic data_pid_toggle,
  input wire logic [4:1] ep_pipe_direction,
  input wire logic usb_irq
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  property p_check_irq; sie_check_fail |=> usb_irq; endproperty
  a_check_irq: assert property (p_check_irq) else $error("check fail lost");
  property p_fault_irq; sie_fifo0_error |=> usb_irq; endproperty
  a_fault_irq: assert property (p_fault_irq) else $error("fifo fault lost");
  property p_flush_sel; fifo_flush != 5'h0 |-> fifo_flush == (5'h1 << endpoint_select); endproperty
  a_flush_sel: assert property (p_flush_sel) else $error("flush hit wrong endpoint");
  property p_flush_set;
    fifo_flush != 5'h0 && !sie_in_done && !sie_pkt_setup && !sie_pkt_other && !usb_bus_reset &&
      !sie_out_data && !sie_out_zero
      |=> (force_underrun & $past(fifo_flush)) == $past(fifo_flush);
  endproperty
  a_flush_set: assert property (p_flush_set) else $error("underrun not armed");
  property p_rsvd; endpoint_select > 3'h4 |-> fifo_flush == 5'h0; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved select acted");
  property p_pipe_reset; $fell(reset) |-> ep_pipe_direction == 4'hd && !data_pid_toggle; endproperty
  a_pipe_reset: assert property (p_pipe_reset) else $error("pipe reset value");
  property p_busreset;
    usb_bus_reset |=> !fifo_request && !fifo_tx_dir && force_underrun == 5'h0;
  endproperty
  a_busreset: assert property (p_busreset) else $error("bus reset missed");
  property p_rd_pipe;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == 32'h9c |-> ##2 s_axi_rdata[31:5] == 27'h0;
  endproperty
  a_rd_pipe: assert property (p_rd_pipe) else $error("unused pipe bits set");
  property p_rd_lat; s_axi_arvalid && s_axi_arready |-> ##2 s_axi_rvalid; endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
  property p_wr_lat;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid;
  endproperty
  a_wr_lat: assert property (p_wr_lat) else $error("write answer late");
  c_flush: cover property (fifo_flush != 5'h0);
  c_busrst: cover property (usb_bus_reset);
  c_rsvd: cover property (endpoint_select > 3'h4 && s_axi_wvalid);
endmodule
bind usbsfc_core usbsfc_core_asserts u_usbsfc_core_asserts (.*);
`default_nettype wire

//--- bench/usbsfc_sie_model.sv
// usbsfc_sie_model: stands in for the usb engine, one-cycle event pulses and live levels
// assumes the bench calls fire and levels from a single process
`timescale 1ns/1ps
`default_nettype none
module usbsfc_sie_model (
  input wire logic clk_sys,
  output logic sie_setup_ok,
  output logic sie_in_done,
  output logic sie_in_token,
  output logic sie_token_active,
  output logic sie_nak_sent,
  output logic sie_check_fail,
  output logic sie_fifo0_error,
  output logic sie_out_data,
  output logic sie_out_zero,
  output logic sie_pkt_setup,
  output logic sie_pkt_other,
  output logic sie_iso_in_evt,
  output logic sie_iso_out_evt,
  output logic [4:0] fifo_ready,
  output logic fifo_read_strobe
);
  logic [11:0] pulse_q = 12'h0;
  assign {fifo_read_strobe, sie_iso_out_evt, sie_iso_in_evt, sie_pkt_other, sie_pkt_setup,
          sie_out_zero, sie_out_data, sie_fifo0_error, sie_check_fail, sie_nak_sent,
          sie_in_done, sie_setup_ok} = pulse_q;
  initial begin
    sie_in_token = 1'b0;
    sie_token_active = 1'b0;
    fifo_ready = 5'h0;
  end
  // one event for exactly one cycle, then a settle edge
  task automatic fire(input int n);
    @(posedge clk_sys);
    pulse_q <= 12'h1 << n;
    @(posedge clk_sys);
    pulse_q <= 12'h0;
    @(posedge clk_sys);
  endtask
  task automatic levels(input logic tok, input logic act, input logic [4:0] rdy);
    @(posedge clk_sys);
    sie_in_token <= tok;
    sie_token_active <= act;
    fifo_ready <= rdy;
    @(posedge clk_sys);
  endtask
endmodule
`default_nettype wire

//--- rtl/usbsfc_core.sv
// usbsfc_core: status, fifo handshake and pipe direction registers of a usb sie
// assumes the sie core drives one-cycle event pulses on clk_sys, and software uses axi4-lite
//
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none

module usbsfc_core
  import usbsfc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic usb_bus_reset,
  // axi4-lite slave
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // sie events and status
  input wire logic sie_setup_ok,
  input wire logic sie_in_done,
  input wire logic sie_in_token,
  input wire logic sie_token_active,
  input wire logic sie_nak_sent,
  input wire logic sie_check_fail,
  input wire logic sie_fifo0_error,
  input wire logic sie_out_data,
  input wire logic sie_out_zero,
  input wire logic sie_pkt_setup,
  input wire logic sie_pkt_other,
  input wire logic sie_iso_in_evt,
  input wire logic sie_iso_out_evt,
  input wire logic [4:0] fifo_ready,
  input wire logic fifo_read_strobe,
  // towards fifo logic and sie
  output logic [2:0] endpoint_select,
  output logic fifo_request,
  output logic fifo_tx_dir,
  output logic [4:0] fifo_flush,
  output logic [4:0] force_underrun,
  output logic [6:0] active_address,
  output logic remote_wake_en,
  output logic data_pid_toggle,
  output logic [4:1] ep_pipe_direction,
  output logic usb_irq
);

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  logic aw_held_q, w_held_q;
  logic [31:0] awaddr_q, wdata_q;
  logic [3:0] wstrb_q;
  logic [31:0] araddr_q;
  logic ar_held_q;

  wire aw_ok = s_axi_awvalid && !aw_held_q && !s_axi_bvalid;
  wire w_ok = s_axi_wvalid && !w_held_q && !s_axi_bvalid;
  wire [31:0] wr_addr = aw_held_q ? awaddr_q : s_axi_awaddr;
  wire [31:0] wr_data = w_held_q ? wdata_q : s_axi_wdata;
  wire [3:0] wr_strb = w_held_q ? wstrb_q : s_axi_wstrb;
  wire wr_fire = (aw_held_q || aw_ok) && (w_held_q || w_ok);
  wire wr_lane0 = wr_fire && wr_strb[0];
  wire [7:0] wd = wr_data[7:0];

  function automatic logic [8:0] reg_index(input logic [31:0] a);
    return a[10:2];
  endfunction

  function automatic logic is_reg(input logic [31:0] a, input logic [7:0] idx);
    return (reg_index(a) == {1'b0, idx}) && (a[31:11] == 21'h0);
  endfunction

  function automatic logic mapped(input logic [31:0] a);
    return is_reg(a, USBSFC_IDX_TOKEN_STATUS) || is_reg(a, USBSFC_IDX_FIFO_CTRL) ||
           is_reg(a, USBSFC_IDX_PIPE_DIR) || is_reg(a, USBSFC_IDX_DEV_ADDR) ||
           is_reg(a, USBSFC_IDX_EP_SELECT) || is_reg(a, USBSFC_IDX_IRQ_STATE);
  endfunction

  // firmware clears by writing zero to the flag's bit; a same-cycle hardware set wins
  function automatic logic sticky_next(input logic hw_set, input logic held,
                                       input logic wr_en, input logic wr_bit);
    return hw_set || (held && !(wr_en && !wr_bit));
  endfunction

  wire wr_ts = wr_lane0 && is_reg(wr_addr, USBSFC_IDX_TOKEN_STATUS);
  wire wr_fc = wr_lane0 && is_reg(wr_addr, USBSFC_IDX_FIFO_CTRL);
  wire wr_pd = wr_lane0 && is_reg(wr_addr, USBSFC_IDX_PIPE_DIR);
  wire wr_da = wr_lane0 && is_reg(wr_addr, USBSFC_IDX_DEV_ADDR);
  wire wr_es = wr_lane0 && is_reg(wr_addr, USBSFC_IDX_EP_SELECT);

  assign s_axi_awready = aw_ok;
  assign s_axi_wready = w_ok;
  assign s_axi_arready = !ar_held_q && !s_axi_rvalid;

  // ----------------------------------------
  // write channel
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= 32'h0;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= USBSFC_RESP_OKAY;
    end else if (wr_fire) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= mapped(wr_addr) ? USBSFC_RESP_OKAY : USBSFC_RESP_SLVERR;
    end else begin
      if (aw_ok) begin
        aw_held_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (w_ok) begin
        w_held_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic addr_defer_q, fifo0_fault_q, out_rcvd_q, check_fail_q, nak_mask_q, nak_evt_q;
  logic [5:0] fc_q;
  logic [4:0] pd_q;
  logic [7:0] dev_addr_q;
  logic [6:0] active_addr_q;
  logic [2:0] ep_sel_q;
  logic [4:0] underrun_q;
  logic [4:0] zero_len_q;
  logic iso_in_evt_q, iso_out_evt_q;

  // zero-length per endpoint; flag shown for the selected one
  wire sel_valid = ep_sel_q <= USBSFC_EP_LAST;
  wire [4:0] sel_onehot = sel_valid ? (5'h01 << ep_sel_q) : 5'h00;
  wire sel_ready = |(fifo_ready & sel_onehot);
  wire flush_cmd = wr_fc && wd[USBSFC_FC_FLUSH];
  wire ts_clr_w = wr_ts;
  wire new_packet = sie_pkt_setup || sie_pkt_other || sie_out_data || sie_out_zero;

  // bits 3, 4 and 6 follow the engine live; nothing is stored for them
  wire [7:0] ts_view = {nak_mask_q, !sie_token_active, check_fail_q, sie_nak_sent,
                        sie_in_token, out_rcvd_q, fifo0_fault_q, addr_defer_q};
  wire [7:0] fc_view = {|(zero_len_q & sel_onehot), sel_ready, fc_q[5:0]};
  wire [7:0] pd_view = {3'h0, pd_q};

  // ----------------------------------------
  // next values of the event flags
  // ----------------------------------------
  wire fifo0_fault_d = sticky_next(sie_fifo0_error, fifo0_fault_q, ts_clr_w,
                                   wd[USBSFC_TS_FIFO0_FAULT]);
  wire check_fail_d = sticky_next(sie_check_fail, check_fail_q, ts_clr_w,
                                  wd[USBSFC_TS_CHECK_FAIL]);
  // a masked nak is dropped, never parked for later
  wire nak_evt_d = sticky_next(sie_nak_sent && !nak_mask_q, nak_evt_q, ts_clr_w,
                               wd[USBSFC_TS_NAK_SENT]);
  wire iso_in_evt_d = sticky_next(sie_iso_in_evt && fc_q[USBSFC_FC_ISO_IN_EN], iso_in_evt_q,
                                  wr_fc, wd[USBSFC_FC_ISO_IN_EN]);
  wire iso_out_evt_d = sticky_next(sie_iso_out_evt && fc_q[USBSFC_FC_ISO_OUT_EN], iso_out_evt_q,
                                   wr_fc, wd[USBSFC_FC_ISO_OUT_EN]);

  // a flushed fifo answers the next host read with an underrun
  wire [4:0] flush_sel = flush_cmd ? sel_onehot : 5'h00;
  wire [4:0] clear_sel = (sie_in_done || new_packet) ? sel_onehot : 5'h00;
  wire [4:0] underrun_d = (underrun_q | flush_sel) & ~clear_sel;
  wire [4:0] zero_len_d = (zero_len_q & ~(fifo_read_strobe ? sel_onehot : 5'h00)) |
                          (sie_out_zero ? sel_onehot : 5'h00);
  // deferred mode waits until the host has read back, immediate mode takes the write
  wire adopt_now = wr_da && !addr_defer_q;
  wire adopt_late = addr_defer_q && sie_in_done;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      addr_defer_q <= 1'b0;
      fifo0_fault_q <= 1'b0;
      out_rcvd_q <= 1'b0;
      check_fail_q <= 1'b0;
      nak_mask_q <= 1'b0;
      nak_evt_q <= 1'b0;
      pd_q <= USBSFC_PD_RESET;
      dev_addr_q <= USBSFC_DA_RESET;
      active_addr_q <= 7'h0;
      ep_sel_q <= 3'h0;
    end else begin
      if (wr_ts) begin
        addr_defer_q <= wd[USBSFC_TS_ADDR_DEFER];
        nak_mask_q <= wd[USBSFC_TS_NAK_MASK];
      end
      fifo0_fault_q <= fifo0_fault_d;
      check_fail_q <= check_fail_d;
      if (sie_out_data) begin
        out_rcvd_q <= 1'b1;
      end else if (sie_setup_ok || (ts_clr_w && !wd[USBSFC_TS_OUT_RCVD])) begin
        out_rcvd_q <= 1'b0;
      end
      nak_evt_q <= nak_evt_d;
      if (wr_pd) begin
        pd_q <= wd[4:0];
      end
      if (wr_es) begin
        ep_sel_q <= wd[2:0];
      end
      if (wr_da) begin
        dev_addr_q <= wd;
      end
      if (adopt_now) begin
        active_addr_q <= wd[7:1];
      end else if (adopt_late) begin
        active_addr_q <= dev_addr_q[7:1];
      end
    end
  end

  // ----------------------------------------
  // fifo control, cleared also by usb bus reset
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (reset || usb_bus_reset) begin
      fc_q <= USBSFC_FC_RESET[5:0];
      underrun_q <= 5'h0;
      zero_len_q <= 5'h0;
      iso_in_evt_q <= 1'b0;
      iso_out_evt_q <= 1'b0;
    end else begin
      if (wr_fc) begin
        fc_q[4:0] <= wd[4:0];
      end
      if (sie_pkt_setup) begin
        fc_q[USBSFC_FC_SETUP] <= 1'b1;
      end else if (sie_pkt_other || sie_out_data || sie_out_zero) begin
        fc_q[USBSFC_FC_SETUP] <= 1'b0;
      end else if (wr_fc) begin
        fc_q[USBSFC_FC_SETUP] <= wd[USBSFC_FC_SETUP];
      end
      underrun_q <= underrun_d;
      zero_len_q <= zero_len_d;
      iso_in_evt_q <= iso_in_evt_d;
      iso_out_evt_q <= iso_out_evt_d;
    end
  end

  // ----------------------------------------
  // read channel
  // ----------------------------------------
  // unmapped words read as zero and answer with a slave error
  wire ar_take = s_axi_arvalid && s_axi_arready;
  wire [7:0] rd_byte = is_reg(araddr_q, USBSFC_IDX_TOKEN_STATUS) ? ts_view :
                       is_reg(araddr_q, USBSFC_IDX_FIFO_CTRL) ? fc_view :
                       is_reg(araddr_q, USBSFC_IDX_PIPE_DIR) ? pd_view :
                       is_reg(araddr_q, USBSFC_IDX_DEV_ADDR) ? dev_addr_q :
                       is_reg(araddr_q, USBSFC_IDX_EP_SELECT) ? {5'h0, ep_sel_q} :
                       is_reg(araddr_q, USBSFC_IDX_IRQ_STATE) ?
                         {5'h0, iso_out_evt_q, iso_in_evt_q, nak_evt_q} : 8'h00;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ar_held_q <= 1'b0;
      araddr_q <= 32'h0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= USBSFC_RESP_OKAY;
    end else begin
      if (ar_take) begin
        ar_held_q <= 1'b1;
        araddr_q <= s_axi_araddr;
      end
      if (ar_held_q) begin
        ar_held_q <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h0, rd_byte};
        s_axi_rresp <= mapped(araddr_q) ? USBSFC_RESP_OKAY : USBSFC_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign endpoint_select = ep_sel_q;
  assign fifo_request = fc_q[USBSFC_FC_REQUEST];
  assign fifo_tx_dir = fc_q[USBSFC_FC_TX_DIR];
  assign fifo_flush = flush_sel;
  assign force_underrun = underrun_q;
  assign active_address = active_addr_q;
  assign remote_wake_en = dev_addr_q[0];
  assign data_pid_toggle = pd_q[0];
  assign ep_pipe_direction = pd_q[4:1];
  assign usb_irq = nak_evt_q || iso_in_evt_q || iso_out_evt_q || fifo0_fault_q ||
                   check_fail_q;

endmodule

`default_nettype wire

//--- rtl/usbsfc_pkg.sv
// usbsfc_pkg: register map, field positions and reset values of the usb sie status block
// assumes 32-bit axi4-lite byte addressing, one register per aligned word
package usbsfc_pkg;

  // ----------------------------------------
  // register indices; the byte address is the index times four
  // ----------------------------------------
  localparam logic [7:0] USBSFC_IDX_TOKEN_STATUS = 8'h25;
  localparam logic [7:0] USBSFC_IDX_FIFO_CTRL = 8'h26;
  localparam logic [7:0] USBSFC_IDX_PIPE_DIR = 8'h27;
  localparam logic [7:0] USBSFC_IDX_DEV_ADDR = 8'h23;
  localparam logic [7:0] USBSFC_IDX_EP_SELECT = 8'h22;
  localparam logic [7:0] USBSFC_IDX_IRQ_STATE = 8'h40;

  // ----------------------------------------
  // token status fields
  // ----------------------------------------
  localparam int USBSFC_TS_ADDR_DEFER = 0;
  localparam int USBSFC_TS_FIFO0_FAULT = 1;
  localparam int USBSFC_TS_OUT_RCVD = 2;
  localparam int USBSFC_TS_IN_TOKEN = 3;
  localparam int USBSFC_TS_NAK_SENT = 4;
  localparam int USBSFC_TS_CHECK_FAIL = 5;
  localparam int USBSFC_TS_TOKEN_IDLE = 6;
  localparam int USBSFC_TS_NAK_MASK = 7;
  localparam logic [7:0] USBSFC_TS_RESET = 8'h40;
  localparam logic [7:0] USBSFC_TS_W1_MASK = 8'ha7;

  // ----------------------------------------
  // fifo handshake control fields
  // ----------------------------------------
  localparam int USBSFC_FC_REQUEST = 0;
  localparam int USBSFC_FC_TX_DIR = 1;
  localparam int USBSFC_FC_FLUSH = 2;
  localparam int USBSFC_FC_ISO_IN_EN = 3;
  localparam int USBSFC_FC_ISO_OUT_EN = 4;
  localparam int USBSFC_FC_SETUP = 5;
  localparam int USBSFC_FC_READY = 6;
  localparam int USBSFC_FC_ZERO_LEN = 7;
  localparam logic [7:0] USBSFC_FC_RESET = 8'h00;
  localparam logic [7:0] USBSFC_FC_W_MASK = 8'h3f;

  // ----------------------------------------
  // pipe direction and address
  // ----------------------------------------
  localparam logic [4:0] USBSFC_PD_RESET = 5'h1a;
  localparam logic [7:0] USBSFC_DA_RESET = 8'h00;
  localparam logic [2:0] USBSFC_EP_LAST = 3'h4;

  localparam logic [1:0] USBSFC_RESP_OKAY = 2'h0;
  localparam logic [1:0] USBSFC_RESP_SLVERR = 2'h2;

endpackage
